//--- logic/tic_pkg.sv
// Package of register map, field positions and timing counts for the timer capture block.
package tic_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_ENABLE_FLAGS = 8'h92;
    localparam logic [7:0] ADDR_EDGE_SELECT  = 8'h93;
    localparam logic [7:0] ADDR_FILTER       = 8'h94;
    localparam logic [7:0] ADDR_TIMER_CTRL   = 8'hc8;
    localparam logic [7:0] ADDR_TIMER_MODE   = 8'hc9;
    localparam logic [7:0] ADDR_RELOAD_LOW   = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HIGH  = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LOW    = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HIGH   = 8'hcd;
    localparam logic [7:0] ADDR_C0_LOW       = 8'he4;
    localparam logic [7:0] ADDR_C0_HIGH      = 8'he4;
    localparam logic [7:0] ADDR_C0_HIGH_ALT  = 8'he5;
    localparam logic [7:0] ADDR_C1_LOW       = 8'he6;
    localparam logic [7:0] ADDR_C1_HIGH      = 8'he7;
    localparam logic [7:0] ADDR_C2_LOW       = 8'hed;
    localparam logic [7:0] ADDR_C2_HIGH      = 8'hee;
    localparam logic [7:0] ADDR_PIN_SEL_A    = 8'hf1;
    localparam logic [7:0] ADDR_PIN_SEL_B    = 8'hf2;
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'ha0;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'ha1;

    // ==========================================================
    // Writable bit masks and reset value
    localparam logic [7:0] MASK_ENABLE_FLAGS = 8'h77;
    localparam logic [7:0] MASK_EDGE_SELECT  = 8'h3f;
    localparam logic [7:0] MASK_FILTER       = 8'h70;
    localparam logic [7:0] MASK_PIN_SEL_B    = 8'h0f;
    localparam logic [7:0] MASK_TIMER_CTRL   = 8'h05;
    localparam logic [7:0] MASK_TIMER_MODE   = 8'h8b;
    localparam logic [7:0] MASK_IRQ          = 8'h0f;
    localparam logic [7:0] RESET_BYTE        = 8'h00;

    // ==========================================================
    // Field positions
    localparam int ENABLE_LSB   = 4;
    localparam int FLAG_LSB     = 0;
    localparam int FILTER_LSB   = 4;
    localparam int RUN_BIT      = 2;
    localparam int MODE_BIT     = 0;
    localparam int AUTOCLR_BIT  = 3;
    localparam int RELOAD_EN    = 7;
    localparam int IRQ_OVF_BIT  = 3;

    // ==========================================================
    // Encodings
    localparam logic [1:0] EDGE_FALL   = 2'h0;
    localparam logic [1:0] EDGE_RISE   = 2'h1;
    localparam logic [1:0] EDGE_BOTH   = 2'h2;
    localparam logic [1:0] TRIG_OVF    = 2'h0;
    localparam logic [3:0] PIN_SEL_MAX = 4'h8;
    localparam int         PIN_COUNT   = 9;
    localparam logic [15:0] COUNT_TOP  = 16'hffff;

    // ==========================================================
    // Timing: the filter needs the new level to stand this long.
    localparam int CLK_PERIOD_NS = 40;
    localparam int FILTER_NS     = 160;
    localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] FILTER_LAST = 3'(FILTER_CYCLES - 1);

endpackage : tic_pkg

//--- logic/tic_capture.sv
// Timer counter with three input capture channels, register port and interrupt.
//
// Summary of operation
// - Counter high byte is an 8-bit read/write register, zero after reset.
// - Bits 6,5,4 enable channels 2,1,0; zero disables the channel.
// - Bits 2,1,0 flag a selected edge on channels 2,1,0.
// - Two-bit edge select per channel: fall, rise, either; 11 reserved.
// - Bits 6,5,4 turn the noise filter on for channels 2,1,0.
// - Each channel holds its 16-bit result in low and high bytes, reset zero.
// - Four-bit pin select picks one of nine pins; other codes mean pin 0.
// - Channel 1 select in bits 7:4, channel 0 in bits 3:0 of one register.
// - Channel 2 select in bits 3:0 of its own register, upper bits reserved.
// - Auto-reload mode with auto-clear zeroes the counter on a capture.
// - Reload trigger: 00 overflow, 01..11 capture on channel 0..2.
// - Run bit low halts and keeps the count; high resumes counting.
`timescale 1ns/1ps
module tic_capture (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset,
    // Register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Capture pins and interrupt
    input  wire logic [8:0] i_capture_pins,
    output logic            o_irq
);

    // ==========================================================
    // Helpers
    // Reserved edge code never matches, so a bad setting cannot capture.
    function automatic logic edge_match(input logic [1:0] sel, input logic prev,
                                        input logic cur);
        case (sel)
            tic_pkg::EDGE_FALL: edge_match = prev & ~cur;
            tic_pkg::EDGE_RISE: edge_match = ~prev & cur;
            tic_pkg::EDGE_BOTH: edge_match = prev ^ cur;
            default:            edge_match = 1'b0;
        endcase
    endfunction : edge_match

    // Out-of-range selections fall back to the first pin.
    function automatic logic pin_mux(input logic [3:0] sel, input logic [8:0] pins);
        if (sel <= tic_pkg::PIN_SEL_MAX)
            pin_mux = pins[sel];
        else
            pin_mux = pins[0];
    endfunction : pin_mux

    // ==========================================================
    // State
    logic [8:0]  sync1_reg, sync1_next, sync2_reg, sync2_next;
    logic [2:0]  filt_lvl_reg, filt_lvl_next, prev_lvl_reg, prev_lvl_next;
    logic [2:0]  filt_cnt_reg [3];
    logic [2:0]  filt_cnt_next [3];
    logic [7:0]  en_flags_reg, en_flags_next, edge_reg, edge_next;
    logic [7:0]  filter_reg, filter_next, pin_a_reg, pin_a_next;
    logic [7:0]  pin_b_reg, pin_b_next, ctrl_reg, ctrl_next;
    logic [7:0]  mode_reg, mode_next, irq_stat_reg, irq_stat_next;
    logic [7:0]  irq_mask_reg, irq_mask_next, rdata_reg, rdata_next;
    logic [15:0] count_reg, count_next, reload_reg, reload_next;
    logic [15:0] result_reg [3];
    logic [15:0] result_next [3];
    logic [3:0]  pin_sel [3];
    logic [2:0]  raw_lvl, chosen_lvl, cap_ev;
    logic        run, overflow, trig_hit, cnt_wr;

    // ==========================================================
    // Input synchronisers, pin routing, filters and edge detection
    always_comb
    begin
        sync1_next = i_capture_pins;
        sync2_next = sync1_reg;
        pin_sel[0] = pin_a_reg[3:0];
        pin_sel[1] = pin_a_reg[7:4];
        pin_sel[2] = pin_b_reg[3:0];
        filt_lvl_next = filt_lvl_reg;
        for (int k = 0; k < 3; k++)
        begin
            raw_lvl[k] = pin_mux(pin_sel[k], sync2_reg);
            filt_cnt_next[k] = 3'h0;
            // A level change counts only while it stands unbroken.
            if (raw_lvl[k] != filt_lvl_reg[k])
            begin
                if (filt_cnt_reg[k] == tic_pkg::FILTER_LAST)
                    filt_lvl_next[k] = raw_lvl[k];
                else
                    filt_cnt_next[k] = filt_cnt_reg[k] + 3'h1;
            end
            chosen_lvl[k] = filter_reg[tic_pkg::FILTER_LSB + k] ?
                            filt_lvl_reg[k] : raw_lvl[k];
            cap_ev[k] = en_flags_reg[tic_pkg::ENABLE_LSB + k] &
                        edge_match(edge_reg[2*k +: 2], prev_lvl_reg[k],
                                   chosen_lvl[k]);
        end
        prev_lvl_next = chosen_lvl;
    end

    // Input state registers; reset picks idle-high so no edge fires at release.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            sync1_reg    <= 9'h1ff;
            sync2_reg    <= 9'h1ff;
            filt_lvl_reg <= 3'h7;
            prev_lvl_reg <= 3'h7;
            for (int k = 0; k < 3; k++)
                filt_cnt_reg[k] <= 3'h0;
        end
        else
        begin
            sync1_reg    <= sync1_next;
            sync2_reg    <= sync2_next;
            filt_lvl_reg <= filt_lvl_next;
            prev_lvl_reg <= prev_lvl_next;
            for (int k = 0; k < 3; k++)
                filt_cnt_reg[k] <= filt_cnt_next[k];
        end
    end

    // ==========================================================
    // Counter, control registers, results and interrupt status
    assign run      = ctrl_reg[tic_pkg::RUN_BIT];
    assign overflow = run && (count_reg == tic_pkg::COUNT_TOP);
    assign cnt_wr   = i_wr && (i_addr == tic_pkg::ADDR_COUNT_LOW ||
                               i_addr == tic_pkg::ADDR_COUNT_HIGH);

    always_comb
    begin
        en_flags_next = en_flags_reg;
        edge_next     = edge_reg;
        filter_next   = filter_reg;
        pin_a_next    = pin_a_reg;
        pin_b_next    = pin_b_reg;
        ctrl_next     = ctrl_reg;
        mode_next     = mode_reg;
        irq_mask_next = irq_mask_reg;
        reload_next   = reload_reg;
        count_next    = count_reg;
        result_next   = result_reg;
        case (mode_reg[1:0])
            tic_pkg::TRIG_OVF: trig_hit = overflow;
            2'h1:              trig_hit = cap_ev[0];
            2'h2:              trig_hit = cap_ev[1];
            default:           trig_hit = cap_ev[2];
        endcase
        // Software writes first; hardware capture below overrides it.
        if (i_wr)
        begin
            case (i_addr)
                tic_pkg::ADDR_ENABLE_FLAGS: en_flags_next = i_wdata & tic_pkg::MASK_ENABLE_FLAGS;
                tic_pkg::ADDR_EDGE_SELECT:  edge_next = i_wdata & tic_pkg::MASK_EDGE_SELECT;
                tic_pkg::ADDR_FILTER:       filter_next = i_wdata & tic_pkg::MASK_FILTER;
                tic_pkg::ADDR_PIN_SEL_A:    pin_a_next = i_wdata;
                tic_pkg::ADDR_PIN_SEL_B:    pin_b_next = i_wdata & tic_pkg::MASK_PIN_SEL_B;
                tic_pkg::ADDR_TIMER_CTRL:   ctrl_next = i_wdata & tic_pkg::MASK_TIMER_CTRL;
                tic_pkg::ADDR_TIMER_MODE:   mode_next = i_wdata & tic_pkg::MASK_TIMER_MODE;
                tic_pkg::ADDR_IRQ_MASK:     irq_mask_next = i_wdata & tic_pkg::MASK_IRQ;
                tic_pkg::ADDR_RELOAD_LOW:   reload_next[7:0] = i_wdata;
                tic_pkg::ADDR_RELOAD_HIGH:  reload_next[15:8] = i_wdata;
                tic_pkg::ADDR_COUNT_LOW:    count_next[7:0] = i_wdata;
                tic_pkg::ADDR_COUNT_HIGH:   count_next[15:8] = i_wdata;
                tic_pkg::ADDR_C0_LOW:       result_next[0][7:0] = i_wdata;
                tic_pkg::ADDR_C0_HIGH_ALT:  result_next[0][15:8] = i_wdata;
                tic_pkg::ADDR_C1_LOW:       result_next[1][7:0] = i_wdata;
                tic_pkg::ADDR_C1_HIGH:      result_next[1][15:8] = i_wdata;
                tic_pkg::ADDR_C2_LOW:       result_next[2][7:0] = i_wdata;
                tic_pkg::ADDR_C2_HIGH:      result_next[2][15:8] = i_wdata;
                default: ;
            endcase
        end
        // A counter byte write wins over counting; software should halt first.
        if (!cnt_wr && run)
        begin
            if (!ctrl_reg[tic_pkg::MODE_BIT] && mode_reg[tic_pkg::AUTOCLR_BIT] && |cap_ev)
                count_next = 16'h0000;
            else if (mode_reg[tic_pkg::RELOAD_EN] && trig_hit)
                count_next = reload_reg;
            else
                count_next = count_reg + 16'h0001;
        end
        // Events set flags and take the pre-update count; set beats a clearing write.
        for (int k = 0; k < 3; k++)
        begin
            if (cap_ev[k])
            begin
                en_flags_next[tic_pkg::FLAG_LSB + k] = 1'b1;
                result_next[k] = count_reg;
            end
        end
        irq_stat_next = (i_rd && i_addr == tic_pkg::ADDR_IRQ_STATUS) ?
                        8'h00 : irq_stat_reg;
        irq_stat_next = irq_stat_next | {4'h0, overflow, cap_ev};
    end

    // Control and data registers, all cleared by reset.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            en_flags_reg <= tic_pkg::RESET_BYTE;
            edge_reg     <= tic_pkg::RESET_BYTE;
            filter_reg   <= tic_pkg::RESET_BYTE;
            pin_a_reg    <= tic_pkg::RESET_BYTE;
            pin_b_reg    <= tic_pkg::RESET_BYTE;
            ctrl_reg     <= tic_pkg::RESET_BYTE;
            mode_reg     <= tic_pkg::RESET_BYTE;
            irq_mask_reg <= tic_pkg::RESET_BYTE;
            irq_stat_reg <= tic_pkg::RESET_BYTE;
            reload_reg   <= 16'h0000;
            count_reg    <= 16'h0000;
            for (int k = 0; k < 3; k++)
                result_reg[k] <= 16'h0000;
        end
        else
        begin
            en_flags_reg <= en_flags_next;
            edge_reg     <= edge_next;
            filter_reg   <= filter_next;
            pin_a_reg    <= pin_a_next;
            pin_b_reg    <= pin_b_next;
            ctrl_reg     <= ctrl_next;
            mode_reg     <= mode_next;
            irq_mask_reg <= irq_mask_next;
            irq_stat_reg <= irq_stat_next;
            reload_reg   <= reload_next;
            count_reg    <= count_next;
            result_reg   <= result_next;
        end
    end

    // ==========================================================
    // Read port: data stand one cycle after the strobe, else zero.
    always_comb
    begin
        rdata_next = 8'h00;
        if (i_rd)
        begin
            case (i_addr)
                tic_pkg::ADDR_ENABLE_FLAGS: rdata_next = en_flags_reg;
                tic_pkg::ADDR_EDGE_SELECT:  rdata_next = edge_reg;
                tic_pkg::ADDR_FILTER:       rdata_next = filter_reg;
                tic_pkg::ADDR_PIN_SEL_A:    rdata_next = pin_a_reg;
                tic_pkg::ADDR_PIN_SEL_B:    rdata_next = pin_b_reg;
                tic_pkg::ADDR_TIMER_CTRL:   rdata_next = ctrl_reg;
                tic_pkg::ADDR_TIMER_MODE:   rdata_next = mode_reg;
                tic_pkg::ADDR_IRQ_MASK:     rdata_next = irq_mask_reg;
                tic_pkg::ADDR_IRQ_STATUS:   rdata_next = irq_stat_reg;
                tic_pkg::ADDR_RELOAD_LOW:   rdata_next = reload_reg[7:0];
                tic_pkg::ADDR_RELOAD_HIGH:  rdata_next = reload_reg[15:8];
                tic_pkg::ADDR_COUNT_LOW:    rdata_next = count_reg[7:0];
                tic_pkg::ADDR_COUNT_HIGH:   rdata_next = count_reg[15:8];
                tic_pkg::ADDR_C0_LOW:       rdata_next = result_reg[0][7:0];
                tic_pkg::ADDR_C0_HIGH_ALT:  rdata_next = result_reg[0][15:8];
                tic_pkg::ADDR_C1_LOW:       rdata_next = result_reg[1][7:0];
                tic_pkg::ADDR_C1_HIGH:      rdata_next = result_reg[1][15:8];
                tic_pkg::ADDR_C2_LOW:       rdata_next = result_reg[2][7:0];
                tic_pkg::ADDR_C2_HIGH:      rdata_next = result_reg[2][15:8];
                default:                    rdata_next = 8'h00;
            endcase
        end
    end

    // Read data register.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    assign o_rdata = rdata_reg;
    assign o_irq   = |(irq_stat_reg & irq_mask_reg);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    sequence s_reload_cause;
        run && !cnt_wr && mode_reg[tic_pkg::RELOAD_EN] && mode_reg[1:0] == 2'h1 &&
        cap_ev[0] && !mode_reg[tic_pkg::AUTOCLR_BIT];
    endsequence

    sequence s_clear_cause;
        run && !cnt_wr && !ctrl_reg[tic_pkg::MODE_BIT] &&
        mode_reg[tic_pkg::AUTOCLR_BIT] && cap_ev != 3'h0;
    endsequence

    sequence s_ovf_reload;
        run && !cnt_wr && mode_reg[tic_pkg::RELOAD_EN] &&
        mode_reg[1:0] == tic_pkg::TRIG_OVF && overflow && cap_ev == 3'h0;
    endsequence

    a_flag_on_event: assert property (cap_ev[1] |=> en_flags_reg[1])
        else $error("capture flag not set after event");
    a_flag_held_set: assert property (en_flags_reg[0] && !(i_wr &&
        i_addr == tic_pkg::ADDR_ENABLE_FLAGS) |=> en_flags_reg[0])
        else $error("capture flag dropped without a write");
    a_result_copy: assert property (cap_ev[0] |=> result_reg[0] == $past(count_reg))
        else $error("result does not hold the counter of the event cycle");
    a_chan_disabled: assert property (!en_flags_reg[6] |-> !cap_ev[2])
        else $error("disabled channel produced an event");
    a_halt_keeps: assert property (!run && !cnt_wr |=> $stable(count_reg))
        else $error("counter moved while halted");
    a_auto_clear: assert property (s_clear_cause |=> count_reg == 16'h0000)
        else $error("counter not cleared on capture");
    a_reload_trig: assert property (s_reload_cause |=> count_reg == $past(reload_reg))
        else $error("counter not reloaded on channel 0 capture");
    a_high_readback: assert property (i_rd && i_addr == tic_pkg::ADDR_COUNT_HIGH
        |=> o_rdata == $past(count_reg[15:8]))
        else $error("count high byte read wrong");
    a_pin_fallback: assert property (pin_a_reg[7:4] > tic_pkg::PIN_SEL_MAX
        |-> raw_lvl[1] == sync2_reg[0])
        else $error("bad pin code did not fall back to pin 0");
    a_rise_detect: assert property (edge_reg[1:0] == tic_pkg::EDGE_RISE &&
        en_flags_reg[4] && !filter_reg[4] && !prev_lvl_reg[0] && raw_lvl[0]
        |-> cap_ev[0])
        else $error("rising edge missed");
    a_filter_holds: assert property ($changed(filt_lvl_reg[1])
        |-> $past(filt_cnt_reg[1]) == tic_pkg::FILTER_LAST)
        else $error("filter passed an unsettled level");
    a_ovf_reload: assert property (s_ovf_reload |=> count_reg == $past(reload_reg))
        else $error("counter not reloaded on overflow");
    a_count_step: assert property (
        run && !cnt_wr && !mode_reg[tic_pkg::RELOAD_EN] && cap_ev == 3'h0
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("running counter did not step by one");
    a_result_held: assert property (
        !cap_ev[2] && !(i_wr && (i_addr == tic_pkg::ADDR_C2_LOW ||
        i_addr == tic_pkg::ADDR_C2_HIGH)) |=> $stable(result_reg[2]))
        else $error("channel 2 result changed without capture or write");
    a_status_sticky: assert property (
        irq_stat_reg[0] && !(i_rd && i_addr == tic_pkg::ADDR_IRQ_STATUS)
        |=> irq_stat_reg[0])
        else $error("capture status bit dropped without a read");

endmodule : tic_capture

//--- dv/tic_pin_model.sv
// Model of the external signals that drive the nine capture pins.
`timescale 1ns/1ps
module tic_pin_model (
    // Clock
    input  wire logic       i_sys_clk,
    // Pin levels seen by the block
    output logic      [8:0] o_pins
);
    // ==========================================================
    // Pin drive
    // Lines idle high, so the block's idle-high synchronisers see no edge at release.
    initial o_pins = 9'h1ff;

    // Changes one pin just after a clock edge; every other pin keeps its level.
    task automatic drive(input int pin, input logic lvl);
        @(posedge i_sys_clk);
        o_pins[pin] <= lvl;
    endtask : drive
endmodule : tic_pin_model

//--- dv/test_timer2_input_capture.sv
// Self-checking bench for the timer capture block with random routes and counts over every edge code.
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module test_timer2_input_capture;
    // ==========================================================
    // Signals
    logic       i_sys_clk;
    logic       i_reset;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic [7:0] o_rdata;
    logic [8:0] pins;
    logic       o_irq;
    int         miscompares = 0;
    int         comparisons = 0;
    integer     seed        = 32'hcbd2207f;
    logic [7:0] d;
    logic [7:0] a;
    logic [7:0] regs [12] = '{8'h92, 8'h93, 8'h94, 8'hcd, 8'he4, 8'he5,
                             8'he6, 8'he7, 8'hed, 8'hee, 8'hf1, 8'hf2};

    // ==========================================================
    // Design and pin model
    tic_capture i_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_capture_pins(pins), .o_irq(o_irq));
    tic_pin_model i_pins (.i_sys_clk(i_sys_clk), .o_pins(pins));

    // Clock at 25 MHz.
    initial
    begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    // ==========================================================
    // Expectation helpers
    // Codes past the last pin fall back to pin zero.
    function automatic logic [3:0] route(input logic [3:0] p);
        return (p > tic_pkg::PIN_SEL_MAX) ? 4'h0 : p;
    endfunction : route

    // Whether an edge code reacts to a falling or a rising step; code 11 never does.
    function automatic logic hit(input logic [1:0] code, input logic fall);
        return (code == tic_pkg::EDGE_BOTH) || (code == (fall ? 2'h0 : 2'h1));
    endfunction : hit

    function automatic logic [7:0] res_addr(input int ch, input logic hi);
        return (ch == 0) ? (hi ? 8'he5 : 8'he4) : (ch == 1) ? (hi ? 8'he7 : 8'he6)
                                                            : (hi ? 8'hee : 8'hed);
    endfunction : res_addr

    // ==========================================================
    // Register bus tasks
    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        @(posedge i_sys_clk);
        i_addr  <= ad;
        i_wdata <= wd;
        i_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [7:0] ad, output logic [7:0] rv);
        @(posedge i_sys_clk);
        i_addr <= ad;
        i_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
        #1 rv = o_rdata;
    endtask : rd

    task automatic chk_rd(input logic [7:0] ad, input logic [7:0] ev);
        logic [7:0] rv;
        rd(ad, rv);
        `CHK(rv, ev)
    endtask : chk_rd

    task automatic wrchk(input logic [7:0] ad, input logic [7:0] mask);
        logic [7:0] r;
        r = 8'($random(seed));
        wr(ad, r);
        chk_rd(ad, r & mask);
    endtask : wrchk

    // Moves a pin and waits long enough for the synchroniser and any filter.
    task automatic step(input int pin, input logic lvl, input int wait_cyc);
        i_pins.drive(pin, lvl);
        repeat (wait_cyc) @(posedge i_sys_clk);
    endtask : step

    // ==========================================================
    // One capture channel: routed pin, edge code, frozen count, fall then rise.
    task automatic capture_case(input int ch, input logic [1:0] code, input logic en);
        logic [3:0]  p;
        logic [15:0] cnt;
        logic        e;
        p   = 4'($random(seed));
        cnt = 16'($random(seed));
        wr(8'hf1, (ch == 0) ? {4'h0, p} : (ch == 1) ? {p, 4'h0} : 8'h00);
        wr(8'hf2, (ch == 2) ? {4'h0, p} : 8'h00);
        wr(8'h93, {6'h0, code} << (2 * ch));
        wr(tic_pkg::ADDR_COUNT_HIGH, cnt[15:8]);
        wr(tic_pkg::ADDR_COUNT_LOW, cnt[7:0]);
        wr(8'h92, {7'h0, en} << (4 + ch));
        // A pin that is not routed must not disturb the channel.
        step((int'(route(p)) + 1) % 9, 1'b0, 6);
        step((int'(route(p)) + 1) % 9, 1'b1, 6);
        for (int lvl = 0; lvl < 2; lvl++)
        begin
            step(int'(route(p)), 1'(lvl), 6);
            e = en & hit(code, lvl == 0);
            rd(8'h92, d);
            `CHK(d[ch], e)
            `CHK(o_irq, e)
            if (e)
            begin
                chk_rd(res_addr(ch, 1'b0), cnt[7:0]);
                chk_rd(res_addr(ch, 1'b1), cnt[15:8]);
            end
            wr(8'h92, {7'h0, en} << (4 + ch));
            chk_rd(8'h92, {7'h0, en} << (4 + ch));
            chk_rd(tic_pkg::ADDR_IRQ_STATUS, {7'h0, e} << ch);
            `CHK(o_irq, 1'b0)
        end
    endtask : capture_case

    // ==========================================================
    // Verdict and end of run
    task automatic close_out;
        if (miscompares == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // Watchdog well beyond the thousand or so cycles that the sequence needs.
    initial
    begin
        repeat (50000) @(posedge i_sys_clk);
        miscompares++;
        close_out();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        i_reset = 1'b1;
        i_addr  = 8'h00;
        i_wdata = 8'h00;
        i_wr    = 1'b0;
        i_rd    = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        foreach (regs[i])
            chk_rd(regs[i], 8'h00);
        chk_rd(8'h50, 8'h00);
        wrchk(tic_pkg::ADDR_COUNT_HIGH, 8'hff);
        wrchk(8'h93, 8'h3f);
        wrchk(8'h94, 8'h70);
        wrchk(8'hf1, 8'hff);
        wrchk(8'hf2, 8'h0f);
        wrchk(8'he6, 8'hff);
        wr(8'h94, 8'h00);
        wr(tic_pkg::ADDR_IRQ_MASK, 8'h07);
        for (int ch = 0; ch < 3; ch++)
            for (int c = 0; c < 4; c++)
                capture_case(ch, 2'(c), 1'b1);
        capture_case(int'($unsigned($random(seed)) % 3), tic_pkg::EDGE_BOTH, 1'b0);
        // A one-cycle glitch is swallowed by the filter, a steady level is not.
        wr(8'hf1, 8'h00);
        wr(8'h93, 8'h00);
        wr(8'h94, 8'h10);
        wr(8'h92, 8'h10);
        i_pins.drive(0, 1'b0);
        step(0, 1'b1, 12);
        rd(8'h92, d);
        `CHK(d[0], 1'b0)
        step(0, 1'b0, 12);
        rd(8'h92, d);
        `CHK(d[0], 1'b1)
        step(0, 1'b1, 12);
        wr(8'h94, 8'h00);
        wr(8'h92, 8'h10);
        rd(tic_pkg::ADDR_IRQ_STATUS, d);
        // Running, halting and resuming the counter.
        wr(tic_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr(tic_pkg::ADDR_COUNT_LOW, 8'h00);
        wr(tic_pkg::ADDR_TIMER_CTRL, 8'h04);
        repeat (100) @(posedge i_sys_clk);
        wr(tic_pkg::ADDR_TIMER_CTRL, 8'h00);
        rd(tic_pkg::ADDR_COUNT_LOW, a);
        `CHK(a >= 8'd100 && a <= 8'd106, 1'b1)
        repeat (20) @(posedge i_sys_clk);
        chk_rd(tic_pkg::ADDR_COUNT_LOW, a);
        wr(tic_pkg::ADDR_TIMER_CTRL, 8'h04);
        repeat (10) @(posedge i_sys_clk);
        wr(tic_pkg::ADDR_TIMER_CTRL, 8'h00);
        rd(tic_pkg::ADDR_COUNT_LOW, d);
        `CHK(d - a >= 8'd10 && d - a <= 8'd14, 1'b1)
        // Auto-clear in auto-reload mode zeroes the count after the copy, whatever the trigger.
        wr(tic_pkg::ADDR_TIMER_MODE, 8'h09);
        wr(tic_pkg::ADDR_COUNT_HIGH, 8'h12);
        wr(tic_pkg::ADDR_TIMER_CTRL, 8'h04);
        step(0, 1'b0, 6);
        wr(tic_pkg::ADDR_TIMER_CTRL, 8'h00);
        chk_rd(8'he5, 8'h12);
        chk_rd(tic_pkg::ADDR_COUNT_HIGH, 8'h00);
        rd(tic_pkg::ADDR_COUNT_LOW, d);
        `CHK(d < 8'h10, 1'b1)
        // A channel 0 capture, then an overflow, each load the reload value.
        d = 8'($random(seed)) | 8'h80;
        wr(tic_pkg::ADDR_RELOAD_LOW, 8'h00);
        wr(tic_pkg::ADDR_RELOAD_HIGH, d);
        wr(8'h93, 8'h02);
        wr(tic_pkg::ADDR_TIMER_MODE, 8'h81);
        wr(tic_pkg::ADDR_TIMER_CTRL, 8'h04);
        step(0, 1'b1, 6);
        wr(tic_pkg::ADDR_TIMER_CTRL, 8'h00);
        chk_rd(tic_pkg::ADDR_COUNT_HIGH, d);
        wr(tic_pkg::ADDR_TIMER_MODE, 8'h80);
        wr(tic_pkg::ADDR_COUNT_HIGH, 8'hff);
        wr(tic_pkg::ADDR_COUNT_LOW, 8'hfe);
        rd(tic_pkg::ADDR_IRQ_STATUS, a);
        wr(tic_pkg::ADDR_TIMER_CTRL, 8'h04);
        repeat (4) @(posedge i_sys_clk);
        wr(tic_pkg::ADDR_TIMER_CTRL, 8'h00);
        chk_rd(tic_pkg::ADDR_COUNT_HIGH, d);
        chk_rd(tic_pkg::ADDR_IRQ_STATUS, 8'h08);
        close_out();
    end
endmodule : test_timer2_input_capture
